/* sadc_regs.vh */
// Functional notes
// - ten-bit result by successive approximation, one selected channel per conversion
// - approximation register loads 200H at start, then updates each bit step
// - control bits 7..4 choose the analog channel, changeable between conversions
// - writing one to control bit 0 starts a conversion when idle; ignored while a conversion runs
// - hardware sets completion flag, control bit 3, when conversion finishes
// - upper eight result bits to high register, lower two to low register
// - after storing result the converter idles until software starts again
// - each new result overwrites result registers unconditionally
// - control bits 2..1 select conversion clock rate
// - ten set-up clocks plus four per bit, fifty conversion clocks total
// - speed code 10 gives conversion clock of four system clocks
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
`define SADC_ADDR_CTRL     8'hD2
`define SADC_ADDR_RES_HI   8'hD3
`define SADC_ADDR_RES_LO   8'hD4
`define SADC_ADDR_IRQ_STAT 8'hD5
`define SADC_ADDR_IRQ_MASK 8'hD6
`define SADC_BIT_START     0
`define SADC_BIT_EOC       3
`define SADC_SPD_LSB       1
`define SADC_CH_LSB        4
`define SADC_SAR_INIT      10'h200
`define SADC_SETUP_CLKS    6'h0A
`define SADC_CLKS_PER_BIT  6'h04
`define SADC_TOTAL_CLKS    6'h32
`define SADC_DIV_SPD0      9'h0FF
`define SADC_DIV_SPD1      9'h01F
`define SADC_DIV_SPD2      9'h003
`define SADC_DIV_SPD3      9'h00F
`endif

/* sadc_result_mem.v */
`timescale 1ns/1ps
// two-entry result store with registered read port
module sadc_result_mem (
  clk,
  ce,
  we,
  wdata_hi,
  wdata_lo,
  rsel,
  rdata
);
  input  wire       clk;
  input  wire       ce;
  input  wire       we;
  input  wire [7:0] wdata_hi;
  input  wire [7:0] wdata_lo;
  input  wire       rsel;
  output reg  [7:0] rdata;

  reg [7:0] mem_r [0:1];

  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem_r[0] <= wdata_hi;
        mem_r[1] <= wdata_lo;
      end
      rdata <= mem_r[rsel];
    end
  end
endmodule

/* sadc_top.v */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sadc_regs.vh"
module sadc_top (
  clk,
  sys_rst,
  ce,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  cmp_in,
  chan_sel,
  sar_dac,
  sample_en,
  irq
);
  input  wire        clk;
  input  wire        sys_rst;
  input  wire        ce;
  input  wire        wb_cyc_i;
  input  wire        wb_stb_i;
  input  wire        wb_we_i;
  input  wire [7:0]  wb_adr_i;
  input  wire        wb_sel_i;
  input  wire [7:0]  wb_dat_i;
  output reg  [7:0]  wb_dat_o;
  output reg         wb_ack_o;
  input  wire        cmp_in;
  output reg  [3:0]  chan_sel;
  output reg  [9:0]  sar_dac;
  output reg         sample_en;
  output reg         irq;

  localparam ST_IDLE  = 3'b001;
  localparam ST_SETUP = 3'b010;
  localparam ST_CONV  = 3'b100;

  // ==================================================
  // registers
  reg  [2:0] state_r;
  reg  [3:0] chan_r;
  reg  [1:0] spd_r;
  reg  [1:0] spd_act_r;
  reg        eoc_r;
  reg  [9:0] sar_r;
  reg  [3:0] bit_idx_r;
  reg  [5:0] clk_cnt_r;
  reg  [8:0] div_r;
  reg  [8:0] div_max;
  reg        irq_stat_r;
  reg        irq_mask_r;
  reg        ack_pend_r;
  reg        rd_mem_r;
  reg  [7:0] rd_reg_r;
  wire [7:0] mem_rdata;
  wire       bus_req;
  wire       wr_ctrl;
  wire       start;
  wire       tick;
  wire       done;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~ack_pend_r;
  assign wr_ctrl = bus_req & wb_we_i & wb_sel_i & (wb_adr_i == `SADC_ADDR_CTRL);
  assign start   = wr_ctrl & wb_dat_i[`SADC_BIT_START];
  assign tick    = (div_r == div_max);
  assign done    = (state_r == ST_CONV) & tick &
                   (clk_cnt_r == (`SADC_TOTAL_CLKS - 6'h01));

  // ==================================================
  // conversion clock divider
  // speed selects divide ratio
  always @* begin
    case (spd_act_r)
      2'b00:   div_max = `SADC_DIV_SPD0;
      2'b01:   div_max = `SADC_DIV_SPD1;
      2'b10:   div_max = `SADC_DIV_SPD2;
      default: div_max = `SADC_DIV_SPD3;
    endcase
  end

  // ==================================================
  // conversion sequencer
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      spd_act_r <= 2'b00;
      sar_r     <= 10'h000;
      bit_idx_r <= 4'h9;
      clk_cnt_r <= 6'h00;
      div_r     <= 9'h000;
      chan_sel  <= 4'h0;
      sar_dac   <= 10'h000;
      sample_en <= 1'b0;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          div_r     <= 9'h000;
          clk_cnt_r <= 6'h00;
          sample_en <= 1'b0;
          if (start) begin
            chan_sel  <= wb_dat_i[7:4];
            spd_act_r <= wb_dat_i[2:1];
            sar_r     <= `SADC_SAR_INIT;
            sar_dac   <= `SADC_SAR_INIT;
            bit_idx_r <= 4'h9;
            sample_en <= 1'b1;
            state_r   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          div_r <= tick ? 9'h000 : div_r + 9'h001;
          if (tick) begin
            clk_cnt_r <= clk_cnt_r + 6'h01;
            if (clk_cnt_r == (`SADC_SETUP_CLKS - 6'h01)) begin
              state_r <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          div_r <= tick ? 9'h000 : div_r + 9'h001;
          if (tick) begin
            clk_cnt_r <= clk_cnt_r + 6'h01;
            // decide one bit each fourth clock
            if (clk_cnt_r[1:0] == 2'b01) begin
              if (!cmp_in) begin
                sar_r[bit_idx_r] <= 1'b0;
              end
              if (bit_idx_r != 4'h0) begin
                sar_r[bit_idx_r - 4'h1] <= 1'b1;
                sar_dac <= (cmp_in ? sar_r : (sar_r & ~(10'h001 << bit_idx_r)))
                           | (10'h001 << (bit_idx_r - 4'h1));
                bit_idx_r <= bit_idx_r - 4'h1;
              end
            end
            if (done) begin
              state_r   <= ST_IDLE;
              sample_en <= 1'b0;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // control register and flags
  always @(posedge clk) begin
    if (sys_rst) begin
      chan_r     <= 4'h0;
      spd_r      <= 2'b00;
      eoc_r      <= 1'b0;
      irq_stat_r <= 1'b0;
      irq_mask_r <= 1'b0;
      irq        <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        chan_r <= wb_dat_i[7:4];
        spd_r  <= wb_dat_i[2:1];
      end
      // set on done wins over clear on start
      if (done) begin
        eoc_r <= 1'b1;
      end else if (start && state_r == ST_IDLE) begin
        eoc_r <= 1'b0;
      end
      if (done) begin
        irq_stat_r <= 1'b1;
      end else if (bus_req && wb_we_i && wb_sel_i &&
                   wb_adr_i == `SADC_ADDR_IRQ_STAT && wb_dat_i[0]) begin
        irq_stat_r <= 1'b0;
      end
      if (bus_req && wb_we_i && wb_sel_i && wb_adr_i == `SADC_ADDR_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[0];
      end
      irq <= irq_stat_r & irq_mask_r;
    end
  end

  // ==================================================
  // result store
  // overwrite results on completion
  sadc_result_mem u_mem (
    .clk      (clk),
    .ce       (ce),
    .we       (done),
    // the last bit decision is still on cmp_in when done fires
    .wdata_hi (sar_r[9:2]),
    .wdata_lo ({6'h00, sar_r[1], cmp_in}),
    .rsel     (wb_adr_i == `SADC_ADDR_RES_LO),
    .rdata    (mem_rdata)
  );

  // ==================================================
  // wishbone slave, ack two cycles after request
  always @(posedge clk) begin
    if (sys_rst) begin
      ack_pend_r <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 8'h00;
      rd_mem_r   <= 1'b0;
      rd_reg_r   <= 8'h00;
    end else if (ce) begin
      wb_ack_o   <= ack_pend_r;
      ack_pend_r <= bus_req;
      if (bus_req) begin
        rd_mem_r <= (wb_adr_i == `SADC_ADDR_RES_HI) | (wb_adr_i == `SADC_ADDR_RES_LO);
        case (wb_adr_i)
          `SADC_ADDR_CTRL:     rd_reg_r <= {chan_r, eoc_r, spd_r, state_r != ST_IDLE};
          `SADC_ADDR_IRQ_STAT: rd_reg_r <= {7'h00, irq_stat_r};
          `SADC_ADDR_IRQ_MASK: rd_reg_r <= {7'h00, irq_mask_r};
          default:             rd_reg_r <= 8'h00;
        endcase
      end
      if (ack_pend_r) begin
        wb_dat_o <= rd_mem_r ? mem_rdata : rd_reg_r;
      end
    end
  end
endmodule

/* sadc_cmp_model.sv */
`timescale 1ns/1ps
module sadc_cmp_model (
  input  wire       clk,
  input  wire [9:0] level,
  input  wire [9:0] sar_dac,
  input  wire       sample_en,
  output wire       cmp_in
);
  reg noise_r = 1'b0;
  // outside a conversion the comparator output is meaningless, so it toggles
  always @(posedge clk) noise_r <= ~noise_r;
  assign cmp_in = sample_en ? (level >= sar_dac) : noise_r;
endmodule

/* sadc_top_properties.sv */
`timescale 1ns/1ps
module sadc_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire       ce,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire       wb_sel_i,
  input wire [7:0] wb_dat_i,
  input wire [7:0] wb_dat_o,
  input wire       wb_ack_o,
  input wire [3:0] chan_sel,
  input wire [9:0] sar_dac,
  input wire       sample_en,
  input wire       irq
);
  reg [13:0] run_r;
  reg        st_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // conversion length and start cause
  always @(posedge clk) begin
    // frozen cycles do not count towards the conversion length
    run_r <= (sys_rst || !sample_en) ? 14'h0000 : (ce ? run_r + 14'h0001 : run_r);
    st_r  <= sys_rst ? 1'b0 : (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i &&
             wb_adr_i == 8'hD2 && wb_dat_i[0]) ? 1'b1 : (sample_en ? 1'b0 : st_r);
  end
  // ==========
  // assertions
  a_ack_two_later: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##1 !wb_ack_o ##1 wb_ack_o)
    else $error("ack not two cycles after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_start_mid_scale: assert property ($rose(sample_en) |-> sar_dac == 10'h200)
    else $error("trial code not mid scale at start");
  a_chan_held: assert property (!$rose(sample_en) |-> $stable(chan_sel))
    else $error("channel changed outside start");
  a_conv_length: assert property ($fell(sample_en) |-> run_r inside {14'd200, 14'd800,
    14'd1600, 14'd12800})
    else $error("conversion length wrong");
  a_start_cause: assert property ($rose(sample_en) |-> st_r)
    else $error("conversion without start write");
  a_irq_after_conv: assert property ($rose(irq) |-> !sample_en)
    else $error("interrupt during conversion");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |->
    wb_dat_o == 8'h00)
    else $error("unmapped read not zero");
  c_conv: cover property ($fell(sample_en));
  c_irq: cover property ($rose(irq));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind sadc_top sadc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_sel(chan_sel),
  .sar_dac(sar_dac), .sample_en(sample_en), .irq(irq));

/* sar_adc_control_bench.sv */
`timescale 1ns/1ps
module sar_adc_control_bench;
  reg        clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg        ce = 1'b1;
  reg        cyc = 1'b0;
  reg        stb = 1'b0;
  reg        we = 1'b0;
  reg        sel = 1'b0;
  reg  [7:0] adr = 8'h00;
  reg  [7:0] dat_i = 8'h00;
  reg  [9:0] level = 10'h000;
  reg  [7:0] rd;
  reg  [7:0] ctl;
  reg  [9:0] frz;
  wire [7:0] dat_o;
  wire       ack;
  wire       cmp_in;
  wire [3:0] chan_sel;
  wire [9:0] sar_dac;
  wire       sample_en;
  wire       irq;
  integer    fails = 0;
  integer    checked = 0;
  integer    i;
  reg [17:0] rows [0:3] = '{{8'h35, 10'h3FF}, {8'h57, 10'h000}, {8'hA3, 10'h155},
                            {8'hF1, 10'h2AA}};
  sadc_top DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cmp_in(cmp_in), .chan_sel(chan_sel), .sar_dac(sar_dac),
    .sample_en(sample_en), .irq(irq));
  sadc_cmp_model u_cmp (.clk(clk), .level(level), .sar_dac(sar_dac),
    .sample_en(sample_en), .cmp_in(cmp_in));
  initial begin
    forever #4 clk = ~clk;
  end
  // ==========
  // bus and check tasks
  task chk(input string s, input [13:0] e, input [13:0] g);
    begin
      checked++;
      if (g !== e) begin
        fails++;
        $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
    end
  endtask
  task wb(input [7:0] a, input w, input [7:0] d, output [7:0] q);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      {cyc, stb, we, sel, adr, dat_i} <= {2'b11, w, 1'b1, a, d};
      do @(negedge clk); while (ack !== 1'b1 && ++n < 50);
      @(posedge clk);
      q = dat_o;
      {cyc, stb} <= 2'b00;
      if (n >= 50) chk("ack", 1, 0);
    end
  endtask
  task poll;
    integer k;
    begin
      k = 0;
      rd = 8'h00;
      while (rd[3] !== 1'b1 && k < 5000) begin
        wb(8'hD2, 1'b0, 8'h00, rd);
        k++;
      end
      chk("done flag", 1, rd[3]);
      chk("idle", 0, rd[0]);
    end
  endtask
  task conv(input [7:0] c);
    begin
      wb(8'hD2, 1'b1, c, rd);
      poll;
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #400000;
    fails++;
    end_of_test;
  end
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    wb(8'hD2, 1'b0, 8'h00, rd);
    chk("control after reset", 0, rd);
    for (i = 0; i < 4; i++) begin
      {ctl, level} = rows[i];
      conv(ctl);
      chk("channel", ctl[7:4], chan_sel);
      wb(8'hD3, 1'b0, 8'h00, rd);
      chk("high", level[9:2], rd);
      wb(8'hD4, 1'b0, 8'h00, rd);
      chk("low", level[1:0], rd);
    end
    level = 10'h0F0;
    wb(8'hD2, 1'b1, 8'h25, rd);
    wb(8'hD2, 1'b0, 8'h00, rd);
    chk("flag cleared busy", 8'h25, rd);
    wb(8'hD2, 1'b1, 8'h94, rd);
    chk("held channel", 4'h2, chan_sel);
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    frz = sar_dac;
    repeat (20) @(posedge clk);
    chk("frozen trial code", frz, sar_dac);
    chk("frozen busy", 1, sample_en);
    ce <= 1'b1;
    poll;
    level = 10'h301;
    conv(8'h25);
    wb(8'hD3, 1'b1, 8'h00, rd);
    wb(8'hD3, 1'b0, 8'h00, rd);
    chk("overwritten high", 8'hC0, rd);
    wb(8'h10, 1'b1, 8'hFF, rd);
    wb(8'h10, 1'b0, 8'h00, rd);
    chk("unmapped", 0, rd);
    wb(8'hD6, 1'b1, 8'h01, rd);
    conv(8'h25);
    chk("irq set", 1, irq);
    wb(8'hD5, 1'b1, 8'h01, rd);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    wb(8'hD6, 1'b1, 8'h00, rd);
    conv(8'h25);
    chk("irq masked", 0, irq);
    wb(8'hD5, 1'b0, 8'h00, rd);
    chk("status sticky", 1, rd[0]);
    end_of_test;
  end
endmodule
